// ---- bench/pmws_core_model.sv ----
/*
  Behavioural model of the core's instruction stream: a no-operation and
  then the wanted opcode, either back to back or with idle gaps.
  Assumes the caller enters the task just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pmws_core_model (
  // Clock.
  input  wire logic  clk,
  // Instruction stream.
  output logic [7:0] opcode,
  output logic       opcodeValid
);
  // Quiet stream at time zero.
  initial begin
    opcode      = 8'h00;
    opcodeValid = 1'b0;
  end
  // Idle cycles show a changing pattern, so a stale opcode never passes for a fresh one.
  task automatic issue(input logic [7:0] op, input int gap);
    @(posedge clk);
    opcode      <= pmws_pkg::OP_NOP;
    opcodeValid <= 1'b1;
    repeat (gap) begin
      @(posedge clk);
      opcodeValid <= 1'b0;
      opcode      <= ~opcode;
    end
    @(posedge clk);
    opcode      <= op;
    opcodeValid <= 1'b1;
    @(posedge clk);
    opcodeValid <= 1'b0;
    opcode      <= ~op;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Self-checking bench of the power mode and watchdog sequencer.
  Assumes a 125 MHz clock and shortened watchdog and delay counts.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int WdCount = 24;
  localparam int DlyCount = 4;
  localparam int RcDiv = 2;
  localparam logic [3:0] AdSrc = pmws_pkg::OFF_STOP_RECOVERY_CONTROL;
  localparam logic [3:0] AdTwo = pmws_pkg::OFF_PORT_TWO_WAKE_SELECT;
  localparam logic [3:0] AdFive = pmws_pkg::OFF_PORT_FIVE_WAKE_SELECT;
  localparam logic [3:0] AdStat = pmws_pkg::OFF_STATUS;
  typedef struct {int sel; logic [31:0] v;} pmws_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0000_0000;
  logic [3:0] avsByteEnable = 4'hF;
  logic irqPending = 1'b0;
  logic [3:0] flagsIn = 4'h0;
  logic [7:0] portTwoPins = 8'h00;
  logic [7:0] portFivePins = 8'h00;
  logic supplyLow = 1'b0;
  wire logic [31:0] avsReadData;
  wire logic [15:0] restartVector;
  wire logic [7:0] opcode;
  wire logic [3:0] flagsOut;
  wire logic avsWaitRequest, opcodeValid, resumeNext, cpuClockEn, timerClockEn, oscEn, coreReset_n;
  int mismatches = 0;
  int checks = 0;
  int k;
  int j;
  logic [31:0] r;
  pmws_note_t notes[$];
  event probeEv;
  string names[7] = '{"readdata", "clockgates", "flags", "vector", "resume", "corereset", "osc"};

  // Free-running clock, 8 ns period.
  always #4 clk = ~clk;

  pmws_sequencer #(.WATCHDOG_COUNT(WdCount), .DELAY_COUNT(DlyCount), .RC_DIVIDE(RcDiv),
    .WATCHDOG_PERM(1'b0)) dut_u (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .opcode(opcode), .opcodeValid(opcodeValid), .irqPending(irqPending), .flagsIn(flagsIn),
    .flagsOut(flagsOut), .resumeNext(resumeNext), .restartVector(restartVector),
    .cpuClockEn(cpuClockEn), .timerClockEn(timerClockEn), .oscEn(oscEn),
    .coreReset_n(coreReset_n), .portTwoPins(portTwoPins), .portFivePins(portFivePins),
    .supplyLow(supplyLow));
  pmws_core_model core_u (.clk(clk), .opcode(opcode), .opcodeValid(opcodeValid));

  // Selects the output that a note refers to.
  function automatic logic [31:0] observe(input int sel);
    case (sel)
      0: return avsReadData;
      1: return {28'h000_0000, cpuClockEn, timerClockEn, oscEn, coreReset_n};
      2: return 32'(flagsOut);
      3: return 32'(restartVector);
      4: return 32'(resumeNext);
      5: return 32'(coreReset_n);
      default: return 32'(oscEn);
    endcase
  endfunction

  task automatic finish_test();
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic fail(input string what, input logic [31:0] e, input logic [31:0] s);
    mismatches++;
    $display("Error %s expected %h seen %h", what, e, s);
  endtask

  // The oldest note is always the one that belongs to the result now showing.
  task automatic take(input logic [31:0] seen);
    pmws_note_t n;
    if (notes.size() == 0) begin
      fail("queue", 32'h0000_0000, seen);
      return;
    end
    n = notes.pop_front();
    checks++;
    if (n.v !== seen) fail(names[n.sel], n.v, seen);
  endtask

  // Watcher: a read completing or a probe taking place consumes one note.
  always @(posedge clk) begin
    if (avsRead === 1'b1 && avsWaitRequest === 1'b0) take(avsReadData);
  end
  always @(probeEv) take(observe(notes[0].sel));

  // Samples at the falling edge, where the outputs have settled.
  task automatic probe(input int sel, input logic [31:0] v);
    @(negedge clk);
    notes.push_back('{sel, v});
    -> probeEv;
    @(posedge clk);
  endtask

  task automatic stays(input int sel, input logic [31:0] v, input int n);
    repeat (n) probe(sel, v);
  endtask

  // Latencies that the rules leave open are waited for under a bound.
  task automatic wait_for(input int sel, input logic [31:0] v, input int bound);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (observe(sel) !== v && i < bound);
    checks++;
    if (observe(sel) !== v) begin
      fail(names[sel], v, observe(sel));
      finish_test();
    end
    @(posedge clk);
  endtask

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    if (avsWaitRequest !== 1'b0) begin
      fail("waitrequest", 32'h0000_0000, 32'h0000_0001);
      finish_test();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    notes.push_back('{0, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // Main sequence: reset, registers, both stop recoveries, halt, watchdog, low supply.
  initial begin
    void'($urandom(32'hf069));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_for(5, 32'h0000_0001, 10);
    rd(AdSrc, 32'h0000_0020);
    rd(AdTwo, 32'h0000_0000);
    rd(AdFive, 32'h0000_0000);
    rd(AdStat, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    probe(3, 32'h0000_000C);
    probe(1, 32'h0000_000F);
    r = $urandom();
    wr(AdTwo, r);
    wr(4'h6, ~r);
    rd(AdTwo, {24'h00_0000, r[7:0]});
    r = $urandom();
    wr(AdFive, r);
    rd(AdFive, {24'h00_0000, r[7:0]});
    k = $urandom_range(7, 0);
    wr(AdTwo, 32'(1 << k));
    wr(AdFive, 32'h0000_0000);
    core_u.issue(pmws_pkg::OP_STOP, 0);
    repeat (3) @(posedge clk);
    stays(1, 32'h0000_0001, 10);
    portTwoPins  <= portTwoPins ^ ~(8'h01 << k);
    portFivePins <= ~portFivePins;
    stays(1, 32'h0000_0001, 10);
    rd(AdStat, 32'h0000_0002);
    portTwoPins[k] <= ~portTwoPins[k];
    wait_for(5, 32'h0000_0000, 40);
    stays(5, 32'h0000_0000, 4);
    wait_for(1, 32'h0000_000F, 100);
    probe(3, 32'h0000_000C);
    rd(AdSrc, 32'h0000_00A0);
    j = $urandom_range(7, 0);
    wr(AdSrc, 32'h0000_0000);
    wr(AdTwo, 32'h0000_0000);
    wr(AdFive, 32'(1 << j));
    portFivePins <= portFivePins ^ ~(8'h01 << j);
    core_u.issue(pmws_pkg::OP_STOP, 2);
    repeat (3) @(posedge clk);
    stays(1, 32'h0000_0001, 6);
    portFivePins[j] <= ~portFivePins[j];
    repeat (2) @(posedge clk);
    portFivePins[j] <= ~portFivePins[j];
    stays(1, 32'h0000_0001, 12);
    portFivePins[j] <= ~portFivePins[j];
    wait_for(5, 32'h0000_0000, 40);
    wait_for(1, 32'h0000_000F, 40);
    rd(AdSrc, 32'h0000_0080);
    flagsIn <= 4'($urandom());
    core_u.issue(pmws_pkg::OP_WATCHDOG, 0);
    probe(2, 32'(flagsIn));
    rd(AdStat, 32'h0000_0008);
    wr(AdStat, 32'h0000_0000);
    rd(AdStat, 32'h0000_0008);
    core_u.issue(pmws_pkg::OP_HALT, 0);
    repeat (3) @(posedge clk);
    stays(1, 32'h0000_0007, 40);
    rd(AdStat, 32'h0000_0009);
    irqPending <= 1'b1;
    wait_for(4, 32'h0000_0001, 20);
    irqPending <= 1'b0;
    core_u.issue(pmws_pkg::OP_WATCHDOG, 0);
    probe(1, 32'h0000_000F);
    wr(AdSrc, 32'h0000_0000);
    repeat (6) begin
      core_u.issue(pmws_pkg::OP_WATCHDOG, $urandom_range(2, 0));
      stays(5, 32'h0000_0001, 12);
    end
    stays(5, 32'h0000_0001, 24);
    wait_for(5, 32'h0000_0000, 60);
    stays(5, 32'h0000_0000, 4);
    wait_for(5, 32'h0000_0001, 60);
    rd(AdSrc, 32'h0000_0020);
    wr(AdSrc, 32'h0000_0000);
    supplyLow <= 1'b1;
    wait_for(5, 32'h0000_0000, 20);
    wait_for(6, 32'h0000_0000, 20);
    stays(5, 32'h0000_0000, 10);
    supplyLow <= 1'b0;
    wait_for(5, 32'h0000_0001, 100);
    rd(AdSrc, 32'h0000_0020);
    rd(AdStat, 32'h0000_0000);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- verilog/pmws_oneshot.sv ----
/*
  Retriggerable one-shot counter clocked by enable ticks.
  Assumes restart, enable and tick come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pmws_oneshot #(
  parameter int COUNT = 1024
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control and status.
  pmws_tick_if.counter      ctl
);
  // A count below two leaves no room between restart and expiry.
  if (COUNT < 2) begin : g_count_check
    $error("pmws_oneshot: COUNT must be at least 2");
  end

  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] count_q;
  logic         busy_q;

  // Restart reloads; ticks count up while enabled; terminal count pulses once.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
      busy_q  <= 1'b0;
    end else if (ctl.restart) begin
      count_q <= '0;
      busy_q  <= 1'b1;
    end else if (busy_q && ctl.enable && ctl.tick) begin
      if (count_q == W'(COUNT - 1)) begin
        busy_q <= 1'b0;
      end
      count_q <= count_q + 1'b1;
    end
  end

  assign ctl.expired = busy_q && ctl.enable && ctl.tick && !ctl.restart
                       && (count_q == W'(COUNT - 1));
  assign ctl.busy    = busy_q;
endmodule
`default_nettype wire

// ---- verilog/pmws_pkg.sv ----
/*
  Shared constants of the power mode and watchdog sequencer: register
  offsets, field positions, reset values, opcodes and timing counts.
  Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package pmws_pkg;
  // Register byte offsets.
  localparam logic [3:0] OFF_STOP_RECOVERY_CONTROL = 4'h0;
  localparam logic [3:0] OFF_PORT_TWO_WAKE_SELECT  = 4'h4;
  localparam logic [3:0] OFF_PORT_FIVE_WAKE_SELECT = 4'h8;
  localparam logic [3:0] OFF_STATUS                = 4'hC;
  // Stop recovery control fields and reset value.
  localparam int         SRC_DELAY_BIT  = 5;
  localparam int         SRC_WARM_BIT   = 7;
  localparam logic [7:0] SRC_RESET_VAL  = 8'h20;
  // Opcodes seen on the instruction stream.
  localparam logic [7:0] OP_NOP      = 8'hFF;
  localparam logic [7:0] OP_STOP     = 8'h6F;
  localparam logic [7:0] OP_HALT     = 8'h7F;
  localparam logic [7:0] OP_WATCHDOG = 8'h5F;
  // Reset vector presented to the core after a restart.
  localparam logic [15:0] RESET_VECTOR = 16'h000C;
  // Wake source hold time in processor clocks when the delay is bypassed.
  localparam logic [3:0] WAKE_HOLD_CLOCKS = 4'h5;
  // Operating modes.
  typedef enum logic [1:0] {PM_RUN, PM_HALT, PM_STOP, PM_STANDBY} pmws_mode_t;
  // Bus answer for unmapped reads.
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ---- verilog/pmws_sequencer.sv ----
/*
  Power mode and watchdog sequencer: run, halt, stop and low-voltage
  standby, clock gating, a watchdog, stop recovery from port edges and a
  power-on delay one-shot. Registers reached over Avalon-MM.
  Assumes the core presents one opcode per cycle with a valid strobe, the
  supply monitor and port pins are asynchronous, and the slow RC oscillator
  is modelled by an enable divider off clk.
*/
// The register offsets and register access over Avalon-MM were decided locally.
// Summary of operation
// - Watchdog is retriggerable one-shot resetting controller.
// - Watchdog expiry acts like power-on reset.
// - Permanent option: runs from power-up, instruction refreshes.
// - Else first instruction starts, later ones restart.
// - Watchdog instruction leaves zero, sign, overflow flags.
// - Enabled watchdog cannot be disabled until reset.
// - Watchdog off in halt, stop, standby.
// - Watchdog on separate RC tick, fixed period.
// - Halt gates CPU clock, keeps oscillator, timer clock.
// - Enabled interrupt ends halt, resumes after halt.
// - Reset ending halt restarts at reset vector.
// - Stop gates CPU, timer clocks, stops oscillator.
// - Stop ends by reset or wake; vector restart.
// - Stop opcode enters stop regardless of pins.
// - Each port pin individually selectable wake source.
// - Either edge on selected pin wakes.
// - Low supply: global reset then oscillator-off standby.
// - Supply good again: power-on reset, resume.
// - Control bit 5 selects delay; bypass needs hold.
// - Power-on reset clears control bit 7.
// - Delay started by power-good, delayed wake, watchdog.
`timescale 1ns/1ps
`default_nettype none
module pmws_sequencer #(
  parameter int WATCHDOG_COUNT = 8192,
  parameter int DELAY_COUNT    = 4096,
  parameter int RC_DIVIDE      = 16,
  parameter bit WATCHDOG_PERM  = 1'b0
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM register slave.
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  // Core instruction stream.
  input  wire logic [7:0]  opcode,
  input  wire logic        opcodeValid,
  input  wire logic        irqPending,
  input  wire logic [3:0]  flagsIn,
  output logic [3:0]       flagsOut,
  output logic             resumeNext,
  output logic [15:0]      restartVector,
  // Clock gates and resets.
  output logic             cpuClockEn,
  output logic             timerClockEn,
  output logic             oscEn,
  output logic             coreReset_n,
  // Wake pins and supply monitor.
  input  wire logic [7:0]  portTwoPins,
  input  wire logic [7:0]  portFivePins,
  input  wire logic        supplyLow
);
  // A divider below two would make the slow tick a constant level.
  if (RC_DIVIDE < 2) begin : g_divide_check
    $error("pmws_sequencer: RC_DIVIDE must be at least 2");
  end

  // All checks below share the one clock and the synchronous reset.
  default clocking cbChecks @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Two-flop synchronisers for pins and the supply monitor.
  logic [16:0] syncA_q, syncB_q, prevPins_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {supplyLow, portFivePins, portTwoPins};
      syncB_q <= syncA_q;
    end
  end
  logic        lowSupply;
  logic [15:0] pins;
  assign lowSupply = syncB_q[16];
  assign pins      = syncB_q[15:0];

  // Registers.
  logic [7:0] stopCtl_q, portTwoSel_q, portFiveSel_q;
  logic       wdEnabled_q;
  pmws_pkg::pmws_mode_t mode_q;

  // RC oscillator stand-in: a tick enable from a divider, apart from the bus.
  logic [$clog2(RC_DIVIDE)-1:0] rcDiv_q;
  logic                          rcTick_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcDiv_q  <= '0;
      rcTick_q <= 1'b0;
    end else begin
      rcTick_q <= (rcDiv_q == '0);
      // Wraps at RC_DIVIDE - 1 so the tick period is fixed by the parameter.
      if (rcDiv_q == ($clog2(RC_DIVIDE))'(RC_DIVIDE - 1)) begin
        rcDiv_q <= '0;
      end else begin
        rcDiv_q <= rcDiv_q + 1'b1;
      end
    end
  end

  // Watchdog and power-on delay one-shots.
  pmws_tick_if wdIf ();
  pmws_tick_if delayIf ();
  pmws_oneshot #(
    .COUNT (WATCHDOG_COUNT)
  ) uWatchdog (
    .clk   (clk),
    .rst_n (rst_n),
    .ctl   (wdIf.counter)
  );
  pmws_oneshot #(
    .COUNT (DELAY_COUNT)
  ) uDelay (
    .clk   (clk),
    .rst_n (rst_n),
    .ctl   (delayIf.counter)
  );

  logic isWdOp, isStopOp, isHaltOp;
  assign isWdOp   = opcodeValid && (opcode == pmws_pkg::OP_WATCHDOG) &&
                    (mode_q == pmws_pkg::PM_RUN);
  assign isStopOp = opcodeValid && (opcode == pmws_pkg::OP_STOP) && (mode_q == pmws_pkg::PM_RUN);
  assign isHaltOp = opcodeValid && (opcode == pmws_pkg::OP_HALT) && (mode_q == pmws_pkg::PM_RUN);

  // Wake edge detection on selected pins, both directions.
  logic [15:0] wakeEdge;
  logic        wakeHit;
  assign wakeEdge = (pins ^ prevPins_q[15:0]) & {portFiveSel_q, portTwoSel_q};
  assign wakeHit  = |wakeEdge;

  // Bypass hold: the wake source must stay changed for five clocks.
  logic [3:0] holdCnt_q;
  logic       holdDone;
  assign holdDone = (holdCnt_q == pmws_pkg::WAKE_HOLD_CLOCKS - 4'h1) && (pins != prevPins_q[15:0]);
  always_ff @(posedge clk) begin
    if (!rst_n || mode_q != pmws_pkg::PM_STOP) begin
      prevPins_q <= {1'b0, syncB_q[15:0]};
      holdCnt_q  <= '0;
    end else if (pins != prevPins_q[15:0] && wakeHit) begin
      holdCnt_q <= (holdCnt_q == 4'hF) ? holdCnt_q : holdCnt_q + 4'h1;
    end else begin
      holdCnt_q <= '0;
      prevPins_q <= {1'b0, pins};
    end
  end

  logic wakeGo;
  assign wakeGo = (mode_q == pmws_pkg::PM_STOP) && !lowSupply &&
                  (stopCtl_q[pmws_pkg::SRC_DELAY_BIT] ? wakeHit : holdDone);

  // Reset-causing event this cycle.
  logic wdFire;
  assign wdFire = wdIf.expired;

  // Mode machine.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= pmws_pkg::PM_RUN;
    end else if (lowSupply) begin
      mode_q <= pmws_pkg::PM_STANDBY;
    end else begin
      unique case (mode_q)
        pmws_pkg::PM_RUN: begin
          if (isStopOp) begin
            mode_q <= pmws_pkg::PM_STOP;
          end else if (isHaltOp) begin
            mode_q <= pmws_pkg::PM_HALT;
          end
        end
        pmws_pkg::PM_HALT: begin
          if (irqPending) begin
            mode_q <= pmws_pkg::PM_RUN;
          end
        end
        pmws_pkg::PM_STOP: begin
          if (wakeGo) begin
            mode_q <= pmws_pkg::PM_RUN;
          end
        end
        pmws_pkg::PM_STANDBY: begin
          mode_q <= pmws_pkg::PM_RUN;
        end
      endcase
    end
  end

  // Watchdog enable: sticky until reset, or always on with the permanent option.
  always_ff @(posedge clk) begin
    if (!rst_n || wdFire || lowSupply) begin
      wdEnabled_q <= WATCHDOG_PERM;
    end else if (isWdOp) begin
      wdEnabled_q <= 1'b1;
    end
  end

  logic wdStartup_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdStartup_q <= 1'b1;
    end else begin
      // A permanent watchdog restarts after every global reset, standby included.
      wdStartup_q <= wdFire || lowSupply;
    end
  end

  // Watchdog counts only in run mode; instruction or permanent start reloads it.
  assign wdIf.restart = isWdOp || (WATCHDOG_PERM && wdStartup_q);
  assign wdIf.enable  = wdEnabled_q && (mode_q == pmws_pkg::PM_RUN);
  assign wdIf.tick    = rcTick_q;

  // Power-on delay is triggered by power-good, delayed wake and watchdog.
  logic delayStart;
  assign delayStart = (mode_q == pmws_pkg::PM_STANDBY && !lowSupply) || wdFire ||
                      (wakeGo && stopCtl_q[pmws_pkg::SRC_DELAY_BIT]);
  assign delayIf.restart = delayStart;
  assign delayIf.enable  = 1'b1;
  assign delayIf.tick    = rcTick_q;

  // Core reset is held while the supply is low, on expiry, and while the delay runs.
  logic coreResetNext_n;
  assign coreResetNext_n = !(lowSupply || wdFire || delayStart || delayIf.busy ||
                             (mode_q == pmws_pkg::PM_STOP && wakeGo));

  // Registered outputs toward the core and clock tree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpuClockEn    <= 1'b1;
      timerClockEn  <= 1'b1;
      oscEn         <= 1'b1;
      coreReset_n   <= 1'b0;
      flagsOut      <= '0;
      resumeNext    <= 1'b0;
      restartVector <= pmws_pkg::RESET_VECTOR;
    end else begin
      cpuClockEn    <= (mode_q == pmws_pkg::PM_RUN) && !isStopOp && !isHaltOp;
      timerClockEn  <= (mode_q == pmws_pkg::PM_RUN || mode_q == pmws_pkg::PM_HALT) &&
                       !isStopOp;
      oscEn         <= !lowSupply && ((mode_q == pmws_pkg::PM_RUN && !isStopOp) ||
                       mode_q == pmws_pkg::PM_HALT);
      coreReset_n   <= coreResetNext_n;
      flagsOut      <= flagsIn;
      resumeNext    <= (mode_q == pmws_pkg::PM_HALT) && irqPending && !lowSupply;
      restartVector <= pmws_pkg::RESET_VECTOR;
    end
  end

  // Stop recovery control: warm-start bit set by a stop wake, cleared by cold start.
  always_ff @(posedge clk) begin
    // Watchdog expiry is a cold start as well, so it clears these too.
    if (!rst_n || lowSupply || wdFire) begin
      stopCtl_q     <= pmws_pkg::SRC_RESET_VAL;
      portTwoSel_q  <= '0;
      portFiveSel_q <= '0;
    end else begin
      // A write lands only on the edge that completes it, never while waiting.
      if (avsWrite && !avsWaitRequest && avsByteEnable[0]) begin
        unique case (avsAddress)
          pmws_pkg::OFF_STOP_RECOVERY_CONTROL: stopCtl_q <= avsWriteData[7:0];
          pmws_pkg::OFF_PORT_TWO_WAKE_SELECT:  portTwoSel_q <= avsWriteData[7:0];
          pmws_pkg::OFF_PORT_FIVE_WAKE_SELECT: portFiveSel_q <= avsWriteData[7:0];
          default: ;
        endcase
      end
      if (wakeGo) begin
        stopCtl_q[pmws_pkg::SRC_WARM_BIT] <= 1'b1;
      end
    end
  end

  // Bus slave: one wait cycle, then the answer on the release edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= '0;
    end else begin
      avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
      unique case (avsAddress)
        pmws_pkg::OFF_STOP_RECOVERY_CONTROL: avsReadData <= {24'h00_0000, stopCtl_q};
        pmws_pkg::OFF_PORT_TWO_WAKE_SELECT:  avsReadData <= {24'h00_0000, portTwoSel_q};
        pmws_pkg::OFF_PORT_FIVE_WAKE_SELECT: avsReadData <= {24'h00_0000, portFiveSel_q};
        pmws_pkg::OFF_STATUS: avsReadData <= {28'h000_0000, wdEnabled_q, 1'b0, mode_q};
        default: avsReadData <= pmws_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Checks. Watchdog expiry and standby entry are built from named sequences.
  sequence sWdExpire;
    wdIf.expired;
  endsequence
  sequence sStandbyHeld;
    mode_q == pmws_pkg::PM_STANDBY ##1 !coreReset_n && !oscEn;
  endsequence
  a_wd_resets_core: assert property (
    sWdExpire |=> !coreReset_n)
    else $error("watchdog expiry did not reset core");
  a_wd_cold_regs: assert property (
    sWdExpire |=> stopCtl_q == pmws_pkg::SRC_RESET_VAL &&
    portTwoSel_q == 8'h00 && portFiveSel_q == 8'h00)
    else $error("watchdog expiry left registers set");
  a_wd_delay_start: assert property (
    sWdExpire |=> delayIf.busy)
    else $error("expiry did not start delay");
  a_delay_holds_core: assert property (
    delayIf.busy |=> !coreReset_n)
    else $error("core released while delay runs");
  a_wd_sticky_on: assert property (
    wdEnabled_q && !wdFire && !lowSupply |=> wdEnabled_q)
    else $error("watchdog disabled");
  a_wd_idle_sleep: assert property (
    mode_q != pmws_pkg::PM_RUN |-> !wdIf.enable)
    else $error("watchdog ran in sleep");
  a_stop_gates_all: assert property (
    isStopOp && !lowSupply |=> ##1 !cpuClockEn && !timerClockEn && !oscEn)
    else $error("stop left a clock running");
  a_halt_keeps_timer: assert property (
    mode_q == pmws_pkg::PM_HALT && $past(mode_q) == pmws_pkg::PM_HALT |->
    timerClockEn && !cpuClockEn)
    else $error("halt gating wrong");
  a_halt_irq_exit: assert property (
    mode_q == pmws_pkg::PM_HALT && irqPending && !lowSupply |=>
    mode_q == pmws_pkg::PM_RUN && resumeNext)
    else $error("interrupt did not end halt");
  a_flags_pass: assert property (
    1'b1 |=> flagsOut == $past(flagsIn))
    else $error("flags altered");
  a_low_standby: assert property (
    lowSupply |=> sStandbyHeld)
    else $error("low supply not handled");
  a_standby_repower: assert property (
    mode_q == pmws_pkg::PM_STANDBY && !lowSupply |=> mode_q == pmws_pkg::PM_RUN)
    else $error("supply good did not resume");
  a_stop_enter: assert property (
    isStopOp && !lowSupply |=> mode_q == pmws_pkg::PM_STOP)
    else $error("stop ignored");
  a_stop_wake_run: assert property (
    wakeGo |=> mode_q == pmws_pkg::PM_RUN && !coreReset_n &&
    restartVector == pmws_pkg::RESET_VECTOR)
    else $error("wake did not restart core");
  a_bypass_hold: assert property (
    wakeGo && !stopCtl_q[pmws_pkg::SRC_DELAY_BIT] |->
    $past(wakeHit, 1) && $past(wakeHit, 4))
    else $error("bypass wake not held");
  a_cold_clears_warm: assert property (
    lowSupply |=> !stopCtl_q[pmws_pkg::SRC_WARM_BIT])
    else $error("warm bit kept");
  a_bus_one_wait: assert property (
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus request not answered");
endmodule
`default_nettype wire

// ---- verilog/pmws_tick_if.sv ----
/*
  Interface between the sequencer and its one-shot counters: a start
  request, a run enable, a tick from the slow oscillator and an expiry.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface pmws_tick_if;
  logic restart;
  logic enable;
  logic tick;
  logic expired;
  logic busy;
  modport owner   (output restart, output enable, output tick, input expired, input busy);
  modport counter (input restart, input enable, input tick, output expired, output busy);
endinterface
`default_nettype wire
